// File: chss_sequencer.sv
// Slot-0 hardscan sequencer top: serial registers, scan FIFO, counter.
// Link signals come from the host; trigger is an asynchronous pin.
`timescale 1ns/1ps
`default_nettype none
module chss_sequencer
  import chss_pkg::*;
(
  // System
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Serial link
  input wire logic serial_shift_clock,
  input wire logic link_rst,
  input wire logic serial_data_in,
  input wire logic slot_select_strobe_n,
  // Trigger and scan control
  input wire logic trigger_zero_line,
  output logic [NSLOTS-1:0] scan_control_line,
  output logic scan_active
);
  logic [CTRL_BITS-1:0] ctrl_word;
  logic [ENTRY_BITS-1:0] entry_word;
  logic ctrl_tgl, entry_tgl;

  chss_serial_rx u_rx (
    .serial_shift_clock(serial_shift_clock),
    .link_rst(link_rst),
    .serial_data_in(serial_data_in),
    .slot_select_strobe_n(slot_select_strobe_n),
    .ctrl_word(ctrl_word),
    .ctrl_tgl(ctrl_tgl),
    .entry_word(entry_word),
    .entry_tgl(entry_tgl)
  );

  // Toggle synchronisers plus edge stage
  logic [2:0] ctgl_r, etgl_r, trig_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctgl_r <= '0;
      etgl_r <= '0;
      trig_r <= '0;
    end else if (ce) begin
      ctgl_r <= {ctgl_r[1:0], ctrl_tgl};
      etgl_r <= {etgl_r[1:0], entry_tgl};
      trig_r <= {trig_r[1:0], trigger_zero_line};
    end
  end
  logic ctrl_ev, entry_ev, trig_rise;
  assign ctrl_ev = ctgl_r[2] ^ ctgl_r[1];
  assign entry_ev = etgl_r[2] ^ etgl_r[1];
  assign trig_rise = trig_r[1] & ~trig_r[2];

  // Words are stable once their toggle is seen (held until next write)
  logic [CTRL_BITS-1:0] ctrl_r;
  logic [ENTRY_BITS-1:0] entry_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= CTRL_RESET;
      entry_r <= '0;
    end else if (ce) begin
      if (ctrl_ev) begin
        ctrl_r <= ctrl_word;
      end
      if (entry_ev) begin
        entry_r <= entry_word;
      end
    end
  end
  logic ctrl_new, entry_new;
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_new <= 1'b0;
      entry_new <= 1'b0;
    end else if (ce) begin
      ctrl_new <= ctrl_ev;
      entry_new <= entry_ev;
    end
  end

  logic srst, rewind, load;
  assign srst = ctrl_new && !ctrl_r[B_SRST_N];
  assign rewind = ctrl_new && !ctrl_r[B_REWIND];
  assign load = ctrl_new && !ctrl_r[B_LOAD_N];

  // Scan list storage, indexed flip-flops
  logic [10:0] mem_r [DEPTH];
  logic [PTR_W:0] count_r;
  logic [PTR_W-1:0] wr_r, rd_r;
  logic full;
  assign full = (count_r == (PTR_W+1)'(DEPTH));

  always_ff @(posedge clk) begin
    if (ce && entry_new && !full && !srst) begin
      mem_r[wr_r] <= entry_r[F_SLOT_HI:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      if (srst) begin
        wr_r <= '0;
        count_r <= '0;
      end else if (entry_new && !full) begin
        wr_r <= wr_r + 1'b1;
        count_r <= count_r + 1'b1;
      end
    end
  end

  function automatic logic [6:0] cnt_of(input logic [10:0] e);
    cnt_of = e[F_CNT_HI:F_CNT_LO];
  endfunction
  function automatic logic [3:0] slot_of(input logic [10:0] e);
    slot_of = e[F_SLOT_HI:F_SLOT_LO] + 4'h1;
  endfunction

  // Sequencer
  chss_state_t st_r;
  logic [6:0] samp_r;
  logic [3:0] slot_r;
  logic last;
  logic [10:0] head, nxt;
  assign head = mem_r[rd_r];
  assign last = ({1'b0, rd_r} + 9'h001) >= count_r;
  assign nxt = last ? mem_r[0] : mem_r[rd_r + 1'b1];

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= CHSS_IDLE;
      rd_r <= '0;
      samp_r <= '0;
      slot_r <= '0;
    end else if (ce) begin
      if (srst) begin
        st_r <= CHSS_IDLE;
        rd_r <= '0;
        samp_r <= '0;
        slot_r <= '0;
      end else if (rewind) begin
        rd_r <= '0;
        st_r <= CHSS_IDLE;
      end else if (load) begin
        samp_r <= cnt_of(head);
        slot_r <= slot_of(head);
      end else begin
        case (st_r)
          CHSS_IDLE: begin
            if (ctrl_r[B_READ] && count_r != '0) begin
              samp_r <= cnt_of(head);
              slot_r <= slot_of(head);
              st_r <= CHSS_RUN;
            end
          end
          CHSS_RUN: begin
            if (!ctrl_r[B_READ]) begin
              st_r <= CHSS_RUN;
            end else if (ctrl_r[B_TCEN] && trig_rise) begin
              if (samp_r != 7'h00) begin
                samp_r <= samp_r - 7'h01;
              end else begin
                st_r <= CHSS_ADV;
              end
            end
          end
          CHSS_ADV: begin
            if (last && ctrl_r[B_ONCE]) begin
              st_r <= CHSS_DONE;
            end else begin
              rd_r <= last ? '0 : rd_r + 1'b1;
              samp_r <= cnt_of(nxt);
              slot_r <= slot_of(nxt);
              st_r <= CHSS_RUN;
            end
          end
          default: begin
            st_r <= CHSS_DONE;
          end
        endcase
      end
    end
  end

  // Outputs registered; lines active low
  always_ff @(posedge clk) begin
    if (rst) begin
      scan_control_line <= '1;
      scan_active <= 1'b0;
    end else if (ce) begin
      scan_active <= (st_r == CHSS_RUN) || (st_r == CHSS_ADV);
      scan_control_line <= '1;
      if (ctrl_r[B_SCEN] && st_r == CHSS_RUN) begin
        scan_control_line[slot_r] <= 1'b0;
      end
    end
  end

  AST_FULL_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && full && entry_new && !srst |=> count_r == $past(count_r))
    else $error("entry accepted while full");
  AST_SRST: assert property (@(posedge clk) disable iff (rst)
    ce && srst |=> count_r == '0 && st_r == CHSS_IDLE)
    else $error("scan reset did not clear");
  AST_APPEND: assert property (@(posedge clk) disable iff (rst)
    ce && entry_new && !full && !srst |=> wr_r == $past(wr_r) + 1'b1)
    else $error("entry not appended");
  AST_REWIND: assert property (@(posedge clk) disable iff (rst)
    ce && rewind && !srst |=> rd_r == '0)
    else $error("rewind ignored");
  AST_SCEN: assert property (@(posedge clk) disable iff (rst)
    ce && !ctrl_r[B_SCEN] |=> scan_control_line == '1)
    else $error("scan line driven while disabled");
  AST_NOTRIG: assert property (@(posedge clk) disable iff (rst)
    ce && !ctrl_r[B_TCEN] && st_r == CHSS_RUN && !ctrl_new
    |=> samp_r == $past(samp_r))
    else $error("counter moved without trigger enable");
  AST_DEC: assert property (@(posedge clk) disable iff (rst)
    ce && st_r == CHSS_RUN && ctrl_r[B_READ] && ctrl_r[B_TCEN] && trig_rise
    && samp_r != 7'h00 && !ctrl_new |=> samp_r == $past(samp_r) - 7'h01)
    else $error("counter not decremented");
  AST_ONCE: assert property (@(posedge clk) disable iff (rst)
    ce && st_r == CHSS_ADV && last && ctrl_r[B_ONCE] && !ctrl_new
    |=> st_r == CHSS_DONE)
    else $error("single pass did not stop");
  AST_NOREAD: assert property (@(posedge clk) disable iff (rst)
    ce && st_r == CHSS_RUN && !ctrl_r[B_READ] && !ctrl_new
    |=> rd_r == $past(rd_r))
    else $error("read while disabled");
endmodule
`default_nettype wire

// File: chss_pkg.sv
// Constants for the chassis hardscan sequencer.
// Assumes a 50 MHz system clock and a host-driven serial shift clock.
// How it works
// - Control register: select pseudo-slot 13, shift eight bits MSB first.
// - Forced-rewind bit written zero returns read position to first entry.
// - Read-enable zero stops FIFO reads; one reads, advancing to the next entry through one advance-state cycle at each entry end.
// - Single-pass one stops after last entry; zero wraps to first.
// - Scan reset bit written zero empties FIFO and resets scanning.
// - Counter load bit written zero loads counter from FIFO output.
// - Scan-control enable zero holds every scan control line high.
// - Trigger clock enable one lets trigger-zero step the scanner.
// - Entries: select pseudo-slot 14, shift sixteen bits MSB first.
// - Each completed entry write appends after the last entry; writes while the FIFO is full are dropped.
// - The scan-list FIFO holds at most 256 entries.
// - Entry bits 10..7 plus one give the module slot.
// - Entry bits 6..0 plus one give the sample count.
// - Entry bits 15..11 are ignored.
// - Serial data is captured on the shift clock rising edge.
// - Shifted data latches when the slot-select strobe goes low.
// - Strobe low shifts sixteen select bits; low four choose slot.
package chss_pkg;
  localparam int CTRL_BITS = 8;
  localparam int ENTRY_BITS = 16;
  localparam int SEL_BITS = 16;
  localparam int DEPTH = 256;
  localparam int PTR_W = 8;
  localparam int NSLOTS = 16;
  localparam logic [3:0] SLOT_CTRL = 4'hD;
  localparam logic [3:0] SLOT_ENTRY = 4'hE;
  localparam int B_REWIND = 6;
  localparam int B_READ = 5;
  localparam int B_ONCE = 4;
  localparam int B_SRST_N = 3;
  localparam int B_LOAD_N = 2;
  localparam int B_SCEN = 1;
  localparam int B_TCEN = 0;
  localparam logic [7:0] CTRL_RESET = 8'h08;
  localparam int F_SLOT_HI = 10;
  localparam int F_SLOT_LO = 7;
  localparam int F_CNT_HI = 6;
  localparam int F_CNT_LO = 0;
  typedef enum logic [1:0] {
    CHSS_IDLE = 2'b00,
    CHSS_RUN = 2'b01,
    CHSS_ADV = 2'b10,
    CHSS_DONE = 2'b11
  } chss_state_t;
endpackage

// File: chss_serial_rx.sv
// Serial link receiver on the host shift clock.
// Host drives shift clock, data and slot-select strobe; sampled here.
`timescale 1ns/1ps
`default_nettype none
module chss_serial_rx
  import chss_pkg::*;
(
  // Link
  input wire logic serial_shift_clock,
  input wire logic link_rst,
  input wire logic serial_data_in,
  input wire logic slot_select_strobe_n,
  // Latched words, toggle on each latch
  output logic [CTRL_BITS-1:0] ctrl_word,
  output logic ctrl_tgl,
  output logic [ENTRY_BITS-1:0] entry_word,
  output logic entry_tgl
);
  logic [SEL_BITS-1:0] shift_r;
  logic [3:0] slot_r;
  logic strobe_q_r;

  // Shift on each rising edge of host clock
  always_ff @(posedge serial_shift_clock) begin
    if (link_rst) begin
      shift_r <= '0;
    end else begin
      shift_r <= {shift_r[SEL_BITS-2:0], serial_data_in};
    end
  end

  // Strobe level sampled in link domain; falling edge latches data.
  // Link clock may stop, so latch happens on the first edge after.
  always_ff @(posedge serial_shift_clock) begin
    if (link_rst) begin
      strobe_q_r <= 1'b1;
      slot_r <= 4'h0;
      ctrl_word <= CTRL_RESET;
      ctrl_tgl <= 1'b0;
      entry_word <= '0;
      entry_tgl <= 1'b0;
    end else begin
      strobe_q_r <= slot_select_strobe_n;
      if (!slot_select_strobe_n && strobe_q_r) begin
        if (slot_r == SLOT_CTRL) begin
          ctrl_word <= shift_r[CTRL_BITS-1:0];
          ctrl_tgl <= ~ctrl_tgl;
        end else if (slot_r == SLOT_ENTRY) begin
          entry_word <= shift_r[ENTRY_BITS-1:0];
          entry_tgl <= ~entry_tgl;
        end
      end else if (slot_select_strobe_n && !strobe_q_r) begin
        slot_r <= shift_r[3:0];
      end
    end
  end
endmodule
`default_nettype wire

// File: chss_host_model.sv
// Host model: the acquisition board on the serial chassis link.
// Tasks are called by the bench; shift clock idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module chss_host_model
  import chss_pkg::*;
(
  // Serial link
  output logic serial_shift_clock,
  output logic serial_data_in,
  output logic slot_select_strobe_n
);
  initial begin
    serial_shift_clock = 1'b1;
    serial_data_in = 1'b0;
    slot_select_strobe_n = 1'b1;
  end
  task automatic bit_out(input logic b);
    serial_data_in = b;
    serial_shift_clock = 1'b0;
    #24 serial_shift_clock = 1'b1;
    #24;
  endtask
  task automatic idle_clocks(input int n);
    repeat (n) bit_out(~serial_data_in);
  endtask
  task automatic put(input logic [3:0] s, input int n, input logic [15:0] v);
    slot_select_strobe_n = 1'b0;
    for (int i = 15; i >= 0; i--) bit_out(i < 4 ? s[i] : 1'b0);
    slot_select_strobe_n = 1'b1;
    // Slot taken on this edge; the spare bit is shifted out later
    bit_out(~serial_data_in);
    for (int i = n - 1; i >= 0; i--) bit_out(v[i]);
    slot_select_strobe_n = 1'b0;
    bit_out(~serial_data_in);
    // Released line shows no stale value
    serial_data_in = ~serial_data_in;
  endtask
  task automatic ctrl(input logic [7:0] v);
    put(SLOT_CTRL, CTRL_BITS, {9'h000, v[6:0]});
  endtask
  task automatic entry(input logic [15:0] v);
    put(SLOT_ENTRY, ENTRY_BITS, v);
  endtask
endmodule
`default_nettype wire

// File: chss_sequencer_tb.sv
// Self-checking bench for the hardscan sequencer.
// Assumes the host model drives the link; trigger pulses come from here.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  mismatches++; $display("wrong value %s exp %h got %h", n, e, a); end end
module chss_sequencer_tb;
  import chss_pkg::*;
  logic clk, rst, link_rst, trig, ce;
  wire sck, sdi, ssn;
  logic [NSLOTS-1:0] lines;
  logic active;
  int mismatches = 0;
  int checks_done = 0;
  chss_host_model host_u (.serial_shift_clock(sck), .serial_data_in(sdi),
    .slot_select_strobe_n(ssn));
  chss_sequencer dut_u (.clk(clk), .rst(rst), .ce(ce),
    .serial_shift_clock(sck), .link_rst(link_rst), .serial_data_in(sdi),
    .slot_select_strobe_n(ssn), .trigger_zero_line(trig),
    .scan_control_line(lines), .scan_active(active));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [NSLOTS-1:0] low(input int s);
    return ~(16'h0001 << s);
  endfunction
  // Lines are skipped where only the run state is defined
  task automatic wait_st(input logic [15:0] e, input logic a, input bit ln);
    int n;
    n = 0;
    while (((ln && lines !== e) || active !== a) && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (ln) `CHK("scan lines", e, lines)
    `CHK("scan active", a, active)
    if (n == 600) begin
      mismatches++;
      summarize();
    end
  endtask
  task automatic pulse(input int k);
    // Let a just-written control word settle before the first edge
    repeat (8) @(posedge clk);
    repeat (k) begin
      @(posedge clk) trig <= 1'b1;
      repeat (6) @(posedge clk);
      trig <= 1'b0;
      repeat (6) @(posedge clk);
    end
    #1;
  endtask
  initial begin
    rst = 1'b1;
    link_rst = 1'b1;
    trig = 1'b0;
    ce = 1'b1;
    host_u.idle_clocks(3);
    @(posedge clk) link_rst <= 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wait_st(16'hFFFF, 1'b0, 1);
    $display("test reset done");
    host_u.entry(16'hF901);
    host_u.entry(16'h0200);
    host_u.ctrl(8'h7F);
    wait_st(low(3), 1'b1, 1);
    // Trigger while frozen must be lost entirely
    @(posedge clk) ce <= 1'b0;
    pulse(1);
    `CHK("frozen lines", low(3), lines)
    @(posedge clk) ce <= 1'b1;
    pulse(1);
    `CHK("count hold", low(3), lines)
    pulse(1);
    wait_st(low(5), 1'b1, 1);
    pulse(1);
    wait_st(16'hFFFF, 1'b0, 0);
    $display("test single pass done");
    host_u.ctrl(8'h47);
    wait_st(16'hFFFF, 1'b0, 1);
    host_u.entry(16'hF901);
    host_u.entry(16'h0200);
    host_u.ctrl(8'h6F);
    wait_st(low(3), 1'b1, 1);
    pulse(3);
    wait_st(low(3), 1'b1, 1);
    pulse(2);
    wait_st(low(5), 1'b1, 1);
    host_u.ctrl(8'h3F);
    pulse(1);
    wait_st(low(3), 1'b1, 1);
    host_u.ctrl(8'h7E);
    pulse(3);
    `CHK("trigger off", low(3), lines)
    host_u.ctrl(8'h7D);
    wait_st(16'hFFFF, 1'b1, 1);
    $display("test control bits done");
    host_u.ctrl(8'h47);
    wait_st(16'hFFFF, 1'b0, 1);
    repeat (256) host_u.entry(16'h0080);
    host_u.entry(16'h0380);
    host_u.ctrl(8'h7F);
    wait_st(low(2), 1'b1, 1);
    pulse(255);
    wait_st(low(2), 1'b1, 1);
    pulse(1);
    wait_st(16'hFFFF, 1'b0, 0);
    $display("test full list done");
    summarize();
  end
endmodule
`default_nettype wire
